/* File: hw/esrm_top.sv */
// i2c read slave with sequential streaming and manual reset supervision
module esrm_top
  import esrm_pkg::*;
#(
  parameter int unsigned RESET_TIMEOUT_CYC = ESRM_RESET_TIMEOUT_CYC
)
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOe_n,
  input wire logic rstHiIn,
  output logic rstHiOut,
  output logic rstHiOe_n,
  input wire logic rstLoIn_n,
  output logic rstLoOut_n,
  output logic rstLoOe_n
);
  // pin synchronisers
  logic sclS1_r, sclS2_r, sdaS1_r, sdaS2_r, sclD_r, sdaD_r;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sclS1_r <= 1'b1;
      sclS2_r <= 1'b1;
      sdaS1_r <= 1'b1;
      sdaS2_r <= 1'b1;
      sclD_r <= 1'b1;
      sdaD_r <= 1'b1;
    end else begin
      sclS1_r <= scl;
      sclS2_r <= sclS1_r;
      sdaS1_r <= sdaIn;
      sdaS2_r <= sdaS1_r;
      sclD_r <= sclS2_r;
      sdaD_r <= sdaS2_r;
    end
  end

  esrm_bus_t bus;
  always_comb begin
    bus.sclRise = sclS2_r & ~sclD_r;
    bus.sclFall = ~sclS2_r & sclD_r;
    bus.start = sclS2_r & sclD_r & sdaD_r & ~sdaS2_r;
    bus.stop = sclS2_r & sclD_r & ~sdaD_r & sdaS2_r;
    bus.sda = sdaS2_r;
  end

  // manual reset inputs
  logic hiLevel, hiRise, loLevel, loFall;
  esrm_sync_filt #(.IDLE(1'b0)) uHi (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .pinIn(rstHiIn),
    .level(hiLevel),
    .rise(hiRise),
    .fall()
  );
  logic loLevelRaw;
  esrm_sync_filt #(.IDLE(1'b1)) uLo (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .pinIn(rstLoIn_n),
    .level(loLevelRaw),
    .rise(),
    .fall(loFall)
  );
  assign loLevel = ~loLevelRaw;

  // reset timer: 0 means idle
  logic [31:0] tmr_r, tmr_nxt;
  logic hiHold_r, hiHold_nxt, loHold_r, loHold_nxt;
  logic memOff_r, memOff_nxt;
  always_comb begin
    tmr_nxt = tmr_r;
    hiHold_nxt = hiHold_r;
    loHold_nxt = loHold_r;
    // edges on a pin we drive ourselves are not manual resets
    if (hiRise && !hiHold_r) begin
      tmr_nxt = RESET_TIMEOUT_CYC;
      loHold_nxt = 1'b1;
    end else if (loFall && !loHold_r) begin
      tmr_nxt = RESET_TIMEOUT_CYC;
      hiHold_nxt = 1'b1;
    end else if (tmr_r > 32'h1) begin
      tmr_nxt = tmr_r - 32'h1;
    end else if (tmr_r == 32'h1) begin
      tmr_nxt = 32'h0;
      hiHold_nxt = 1'b0;
      loHold_nxt = 1'b0;
    end
    memOff_nxt = hiLevel | loLevel | hiHold_nxt | loHold_nxt;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tmr_r <= 32'h0;
      hiHold_r <= 1'b0;
      loHold_r <= 1'b0;
      memOff_r <= 1'b0;
    end else begin
      tmr_r <= tmr_nxt;
      hiHold_r <= hiHold_nxt;
      loHold_r <= loHold_nxt;
      memOff_r <= memOff_nxt;
    end
  end

  // open-drain reset drivers: drive active level while held
  logic rstHiOe_r, rstLoOe_r;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rstHiOe_r <= 1'b1;
      rstLoOe_r <= 1'b1;
    end else begin
      rstHiOe_r <= ~hiHold_nxt;
      rstLoOe_r <= ~loHold_nxt;
    end
  end
  assign rstHiOut = 1'b1;
  assign rstLoOut_n = 1'b0;
  assign rstHiOe_n = rstHiOe_r;
  assign rstLoOe_n = rstLoOe_r;

  // i2c slave
  esrm_state_t st_r, st_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic [10:0] addr_r, addr_nxt;
  logic rw_r, rw_nxt, wrPhase_r, wrPhase_nxt;
  logic sdaOe_r, sdaOe_nxt;
  logic inAck_r, inAck_nxt;
  esrm_mem_t memReq;
  logic [7:0] rdData;

  esrm_mem uMem (
    .clk_sys(clk_sys),
    .req(memReq),
    .rdData(rdData)
  );

  always_comb begin
    st_nxt = st_r;
    sh_nxt = sh_r;
    cnt_nxt = cnt_r;
    addr_nxt = addr_r;
    rw_nxt = rw_r;
    wrPhase_nxt = wrPhase_r;
    sdaOe_nxt = sdaOe_r;
    inAck_nxt = inAck_r;
    memReq.addr = addr_r;
    memReq.rdReq = 1'b1;
    if (bus.stop) begin
      st_nxt = ESRM_IDLE;
      sdaOe_nxt = 1'b1;
      inAck_nxt = 1'b0;
      wrPhase_nxt = 1'b0;
    end else if (bus.start) begin
      st_nxt = memOff_r ? ESRM_IDLE : ESRM_DEVADDR;
      cnt_nxt = 3'h0;
      wrPhase_nxt = 1'b0;
      sdaOe_nxt = 1'b1;
      inAck_nxt = 1'b0;
    end else begin
      case (st_r)
        ESRM_IDLE: begin
          sdaOe_nxt = 1'b1;
        end
        ESRM_DEVADDR, ESRM_WRADDR: begin
          // bits counted on rising scl, byte closed on the next fall
          if (bus.sclRise) begin
            sh_nxt = {sh_r[6:0], bus.sda};
            cnt_nxt = cnt_r + 3'h1;
            if (cnt_r == ESRM_BIT_LAST) begin
              wrPhase_nxt = 1'b1;
            end
          end
          if (bus.sclFall) begin
            if (wrPhase_r) begin
              wrPhase_nxt = 1'b0;
              if (st_r == ESRM_WRADDR) begin
                addr_nxt = {addr_r[10:8], sh_r};
                st_nxt = ESRM_ACK_WR;
                sdaOe_nxt = 1'b0;
              end else if (sh_r[7:4] == ESRM_DEV_TYPE && !memOff_r) begin
                rw_nxt = sh_r[0];
                addr_nxt = {sh_r[3:1], addr_r[7:0]};
                st_nxt = ESRM_ACK_ADDR;
                sdaOe_nxt = 1'b0;
              end else begin
                st_nxt = ESRM_WAITSTOP;
              end
            end
          end
        end
        ESRM_ACK_ADDR: begin
          if (bus.sclFall) begin
            if (rw_r) begin
              sh_nxt = rdData;
              sdaOe_nxt = rdData[7];
              cnt_nxt = 3'h1;
              addr_nxt = addr_r + 11'h1;
              st_nxt = ESRM_TXDATA;
            end else begin
              sdaOe_nxt = 1'b1;
              cnt_nxt = 3'h0;
              st_nxt = ESRM_WRADDR;
            end
          end
        end
        ESRM_ACK_WR: begin
          if (bus.sclFall) begin
            sdaOe_nxt = 1'b1;
            st_nxt = ESRM_WAITSTOP;
          end
        end
        ESRM_TXDATA: begin
          if (bus.sclFall) begin
            cnt_nxt = cnt_r + 3'h1;
            if (cnt_r == 3'h0) begin
              sdaOe_nxt = 1'b1;
              st_nxt = ESRM_RXACK;
            end else begin
              sdaOe_nxt = sh_r[3'h7 - cnt_r];
            end
          end
        end
        ESRM_RXACK: begin
          if (bus.sclRise) begin
            inAck_nxt = ~bus.sda;
          end
          if (bus.sclFall) begin
            if (inAck_r && !memOff_r) begin
              sh_nxt = rdData;
              sdaOe_nxt = rdData[7];
              cnt_nxt = 3'h1;
              addr_nxt = addr_r + 11'h1;
              st_nxt = ESRM_TXDATA;
            end else begin
              sdaOe_nxt = 1'b1;
              st_nxt = ESRM_WAITSTOP;
            end
          end
        end
        ESRM_WAITSTOP: begin
          sdaOe_nxt = 1'b1;
        end
        default: begin
          st_nxt = ESRM_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_r <= ESRM_IDLE;
      sh_r <= 8'h00;
      cnt_r <= 3'h0;
      addr_r <= 11'h000;
      rw_r <= 1'b0;
      wrPhase_r <= 1'b0;
      sdaOe_r <= 1'b1;
      inAck_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      sh_r <= sh_nxt;
      cnt_r <= cnt_nxt;
      addr_r <= addr_nxt;
      rw_r <= rw_nxt;
      wrPhase_r <= wrPhase_nxt;
      sdaOe_r <= sdaOe_nxt;
      inAck_r <= inAck_nxt;
    end
  end

  assign sdaOe_n = sdaOe_r;
endmodule

/* File: hw/esrm_pkg.sv */
// constants and types for the serial eeprom read path with manual reset
// What this block does
// - a sequential read starts as a current-address or random read and streams after the first byte.
// - each master acknowledge of a received byte makes the device send another 8-bit byte while the memory is enabled.
// - on a missing acknowledge the device releases data and waits for a stop.
// - the full-width address counter steps by one after each byte sent.
// - past address 2047 the counter wraps to zero and data keeps flowing.
// - either reset pin also acts as a manual reset input, sensed on its active edge only.
// - a rising edge is sensed on the active-high pin and a falling edge on the active-low pin.
// - an active edge starts a 200ms timer that holds the complementary reset output active.
// - when the timer expires the complementary output goes inactive even if the input stays active.
// - the memory is disabled while either reset pin is active.
// - while a manual reset outlasts the timeout no bus access is acknowledged.
package esrm_pkg;
  localparam int unsigned ESRM_CLK_HZ = 40000000;
  localparam int unsigned ESRM_RESET_TIMEOUT_MS = 200;
  localparam int unsigned ESRM_RESET_TIMEOUT_CYC = (ESRM_CLK_HZ / 1000) * ESRM_RESET_TIMEOUT_MS;
  localparam int unsigned ESRM_FILT_LEN = 4;
  localparam int unsigned ESRM_ADDR_W = 11;
  localparam logic [10:0] ESRM_ADDR_TOP = 11'h7ff;
  localparam logic [3:0] ESRM_DEV_TYPE = 4'ha;
  localparam logic [2:0] ESRM_BIT_LAST = 3'h7;
  // power-on fill pattern of the array, arbitrary
  localparam logic [7:0] ESRM_FILL_MUL = 8'h07;
  localparam logic [7:0] ESRM_FILL_ADD = 8'h03;

  typedef enum logic [2:0] {
    ESRM_IDLE = 3'b000,
    ESRM_DEVADDR = 3'b001,
    ESRM_ACK_ADDR = 3'b010,
    ESRM_WRADDR = 3'b011,
    ESRM_ACK_WR = 3'b100,
    ESRM_TXDATA = 3'b101,
    ESRM_RXACK = 3'b110,
    ESRM_WAITSTOP = 3'b111
  } esrm_state_t;

  typedef struct packed {
    logic sclRise;
    logic sclFall;
    logic start;
    logic stop;
    logic sda;
  } esrm_bus_t;

  typedef struct packed {
    logic [10:0] addr;
    logic rdReq;
  } esrm_mem_t;
endpackage

/* File: hw/esrm_sync_filt.sv */
// two-flop synchroniser with majority-free stable filter and edge outputs
module esrm_sync_filt
  import esrm_pkg::*;
#(
  parameter logic IDLE = 1'b0
)
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic pinIn,
  output logic level,
  output logic rise,
  output logic fall
);
  logic sync1_r, sync2_r, sync1_nxt, sync2_nxt;
  logic [ESRM_FILT_LEN-1:0] hist_r, hist_nxt;
  logic level_r, level_nxt;

  always_comb begin
    sync1_nxt = pinIn;
    sync2_nxt = sync1_r;
    hist_nxt = {hist_r[ESRM_FILT_LEN-2:0], sync2_r};
    level_nxt = level_r;
    if (&hist_r) begin
      level_nxt = 1'b1;
    end else if (~|hist_r) begin
      level_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sync1_r <= IDLE;
      sync2_r <= IDLE;
      hist_r <= {ESRM_FILT_LEN{IDLE}};
      level_r <= IDLE;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
      hist_r <= hist_nxt;
      level_r <= level_nxt;
    end
  end

  // previous level starts at idle so reset gives no false edge
  logic prev_r;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      prev_r <= IDLE;
    end else begin
      prev_r <= level_r;
    end
  end

  assign level = level_r;
  assign rise = level_r & ~prev_r;
  assign fall = ~level_r & prev_r;
endmodule

/* File: hw/esrm_mem.sv */
// 2048 byte storage array with registered read port
module esrm_mem
  import esrm_pkg::*;
(
  input wire logic clk_sys,
  input wire esrm_mem_t req,
  output logic [7:0] rdData
);
  logic [7:0] store [0:2047];
  logic [7:0] rdData_r;

  // power-on contents, no write path in this block
  initial begin
    for (int i = 0; i < 2048; i++) begin
      store[i] = (8'(i) * ESRM_FILL_MUL + ESRM_FILL_ADD) ^ {5'h00, 3'(i >> 8)};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (req.rdReq) begin
      rdData_r <= store[req.addr];
    end
  end

  assign rdData = rdData_r;
endmodule

/* File: verif/esrm_top_chk.sv */
// checker on the data pin and the manual reset outputs
module esrm_top_chk
  import esrm_pkg::*;
#(
  parameter int unsigned RESET_TIMEOUT_CYC = 100
)
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic scl,
  input wire logic sdaIn,
  input wire logic sdaOe_n,
  input wire logic rstHiIn,
  input wire logic rstHiOut,
  input wire logic rstHiOe_n,
  input wire logic rstLoIn_n,
  input wire logic rstLoOut_n,
  input wire logic rstLoOe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TLO = RESET_TIMEOUT_CYC - 2;
  localparam int THI = RESET_TIMEOUT_CYC + 2;
  int loCnt_r;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // length of the current low output hold
  always_ff @(posedge clk_sys) begin
    loCnt_r <= (sys_rst || rstLoOe_n) ? 0 : loCnt_r + 1;
  end
  sequence s_loStart;
    $fell(rstLoOe_n);
  endsequence
  sequence s_loKeep;
    !rstLoOe_n [*8];
  endsequence
  property p_outLevels;
    rstHiOut && !rstLoOut_n;
  endproperty
  property p_loCause;
    s_loStart |-> $past(rstHiIn, 4);
  endproperty
  property p_hiCause;
    $fell(rstHiOe_n) |-> !$past(rstLoIn_n, 4);
  endproperty
  property p_loHold;
    s_loStart |=> s_loKeep;
  endproperty
  property p_loEnd;
    $rose(rstLoOe_n) |-> $past(loCnt_r) inside {[TLO:THI]};
  endproperty
  property p_loBound;
    loCnt_r <= THI;
  endproperty
  property p_memOff;
    $fell(sdaOe_n) |-> rstHiOe_n && rstLoOe_n && !rstHiIn && rstLoIn_n;
  endproperty
  property p_sdaLow;
    $changed(sdaOe_n) |-> !scl && !$past(scl);
  endproperty
  a_outLevels: assert property (p_outLevels) else $error("reset pin drive levels wrong");
  a_loCause: assert property (p_loCause) else $error("low hold without high pin edge");
  a_hiCause: assert property (p_hiCause) else $error("high hold without low pin edge");
  a_loHold: assert property (p_loHold) else $error("low hold ended too soon");
  a_loEnd: assert property (p_loEnd) else $error("low hold length wrong");
  a_loBound: assert property (p_loBound) else $error("low hold not released");
  a_memOff: assert property (p_memOff) else $error("sda pulled during reset");
  a_sdaLow: assert property (p_sdaLow) else $error("sda moved while scl high");
endmodule
bind esrm_top esrm_top_chk #(.RESET_TIMEOUT_CYC(RESET_TIMEOUT_CYC)) i_chk (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .scl(scl), .sdaIn(sdaIn), .sdaOe_n(sdaOe_n),
  .rstHiIn(rstHiIn), .rstHiOut(rstHiOut), .rstHiOe_n(rstHiOe_n), .rstLoIn_n(rstLoIn_n),
  .rstLoOut_n(rstLoOut_n), .rstLoOe_n(rstLoOe_n));

/* File: verif/esrm_i2c_mst.sv */
// i2c master model with optional slow low phase
module esrm_i2c_mst (
  output logic scl,
  output logic sdaDrv,
  input wire logic sdaW
);
  timeunit 1ns;
  timeprecision 1ps;
  int slowNs = 0;
  initial begin
    scl = 1'b1;
    sdaDrv = 1'b1;
  end
  task automatic bitx(input logic b, output logic r);
    scl = 1'b0;
    #(50 + slowNs) sdaDrv = b;
    #50 scl = 1'b1;
    #50 r = sdaW;
    #50;
  endtask
  // start when first is 1, stop when 0
  task automatic cond(input logic first);
    scl = 1'b0;
    #50 sdaDrv = first;
    #50 scl = 1'b1;
    #50 sdaDrv = !first;
    #50;
  endtask
  task automatic wrByte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) bitx(d[i], ack);
    bitx(1'b1, ack);
  endtask
  task automatic rdByte(input logic more, output logic [7:0] d);
    logic r;
    d = 8'h00;
    for (int i = 0; i < 8; i++) begin
      bitx(1'b1, r);
      d = {d[6:0], r};
    end
    bitx(!more, r);
  endtask
endmodule

/* File: verif/esrm_top_tb.sv */
// bench for the read slave with manual reset
module esrm_top_tb import esrm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TMO = 100;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic scl;
  logic sdaDrv;
  logic sdaOe_n;
  logic rstHiOut;
  logic rstHiOe_n;
  logic rstLoOut_n;
  logic rstLoOe_n;
  logic tbHi = 1'b0;
  logic tbLo_n = 1'b1;
  wire logic sdaW = sdaDrv & sdaOe_n;
  wire logic hiPin = tbHi | (!rstHiOe_n & rstHiOut);
  wire logic loPin_n = tbLo_n & (rstLoOe_n | rstLoOut_n);
  int bad_count = 0;
  int num_checks = 0;
  int seed = 74237;
  always #12.5 clk_sys = ~clk_sys;
  esrm_i2c_mst i_mst (.scl(scl), .sdaDrv(sdaDrv), .sdaW(sdaW));
  esrm_top #(.RESET_TIMEOUT_CYC(TMO)) i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .scl(scl), .sdaIn(sdaW), .sdaOe_n(sdaOe_n), .rstHiIn(hiPin), .rstHiOut(rstHiOut),
    .rstHiOe_n(rstHiOe_n), .rstLoIn_n(loPin_n), .rstLoOut_n(rstLoOut_n),
    .rstLoOe_n(rstLoOe_n));
  function automatic logic [7:0] devByte(input logic [10:0] a, input logic rd);
    return {ESRM_DEV_TYPE, a[10:8], rd};
  endfunction
  function automatic logic [7:0] expByte(input logic [10:0] a);
    return (a[7:0] * ESRM_FILL_MUL + ESRM_FILL_ADD) ^ {5'h00, a[10:8]};
  endfunction
  task automatic chk(input string nm, input int e, input logic [7:0] g);
    num_checks++;
    if (g !== e[7:0]) begin
      bad_count++;
      $display("MISMATCH %s expected %0h seen %h", nm, e[7:0], g);
    end
  endtask
  task automatic sel(input logic [7:0] b, input int e);
    logic a;
    i_mst.cond(1'b1);
    i_mst.wrByte(b, a);
    chk("ack", e, a);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask
  task automatic waitOe(input bit lo, output int n);
    n = 0;
    while ((lo ? rstLoOe_n : rstHiOe_n) !== 1'b0 && n < 400) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #500us;
    bad_count++;
    final_report();
  end
  initial begin
    logic a;
    logic [10:0] ad;
    logic [7:0] d;
    int n;
    time t0;
    cyc(8);
    sys_rst = 1'b0;
    cyc(10);
    for (int k = 0; k < 4; k++) begin
      ad = (k == 3) ? ESRM_ADDR_TOP : 11'($random(seed));
      n = 2 + ($random(seed) & 3);
      i_mst.slowNs = k[0] ? 150 : 0;
      sel(devByte(ad, 1'b0), 0);
      i_mst.wrByte(ad[7:0], a);
      chk("addrAck", 0, a);
      sel(devByte(ad, 1'b1), 0);
      for (int j = 0; j < n; j++) begin
        i_mst.rdByte(j < n - 1, d);
        chk("rdData", expByte(ad + 11'(j)), d);
      end
      i_mst.bitx(1'b1, a);
      chk("afterNack", 1, a);
      i_mst.cond(1'b0);
    end
    n = $random(seed) & 7;
    sel({(n[2:0] == 3'h2) ? 4'h5 : {n[2:0], 1'b1}, 4'h1}, 1);
    i_mst.cond(1'b0);
    i_mst.slowNs = 0;
    tbHi = 1'b1;
    waitOe(1'b1, n);
    t0 = $time;
    chk("loStart", 1, n < 20);
    sel(devByte(11'h0, 1'b1), 1);
    i_mst.cond(1'b0);
    cyc(1);
    while (rstLoOe_n === 1'b0 && n < 400) begin
      cyc(1);
      n++;
    end
    n = int'(($time - t0) / 25);
    chk("loLen", 1, n > TMO - 20 && n < TMO + 20);
    sel(devByte(11'h0, 1'b1), 1);
    i_mst.cond(1'b0);
    chk("levelOnly", 1, rstLoOe_n);
    tbHi = 1'b0;
    cyc(3 * TMO);
    sel(devByte(11'h0, 1'b1), 0);
    i_mst.rdByte(1'b0, d);
    i_mst.cond(1'b0);
    tbLo_n = 1'b0;
    cyc(2);
    tbLo_n = 1'b1;
    waitOe(1'b0, n);
    chk("glitch", 1, n == 400);
    tbLo_n = 1'b0;
    waitOe(1'b0, n);
    chk("hiStart", 1, n < 20);
    cyc(30 + ($random(seed) & 31));
    tbLo_n = 1'b1;
    cyc(3 * TMO);
    chk("hiEnd", 1, rstHiOe_n);
    final_report();
  end
endmodule
